// File: pcit_arb.sv
// central arbiter: round robin, parking, broken master removal
`timescale 1ns/1ns
`default_nettype none
`include "pcit_params.svh"
module pcit_arb #(
  parameter int NAG = `PCIT_DEF_NAG,
  parameter int PARK = 0,
  parameter bit PARK_EN = 1'b1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic [NAG-1:0] req_n,
  output logic [NAG-1:0] gnt_n,
  output logic [NAG-1:0] broken_o
);
  import pcit_pkg::*;
  localparam int IW = $clog2(NAG);

  if (NAG < 2 || PARK >= NAG) begin : g_chk
    $error("pcit_arb: need at least two agents and a valid park agent");
  end

  logic [NAG-1:0] gnt_q, gnt_d, broken_q, broken_d, req, win_any, win_oth, park_vec;
  logic [IW-1:0] last_q, last_d;
  logic [`PCIT_BCNT_W-1:0] bcnt_q, bcnt_d;
  logic busy, cur_req, trip;

  // first requester after the last owner
  function automatic logic [NAG-1:0] pick(input logic [NAG-1:0] r, input int from);
    logic [NAG-1:0] g;
    int k;
    g = '0;
    for (int i = NAG; i >= 1; i--) begin
      k = (from + i) % NAG;
      if (r[k]) begin
        g = '0;
        g[k] = 1'b1;
      end
    end
    return g;
  endfunction

  // ****************************************
  // grant selection
  // ****************************************
  always_comb begin
    busy = ~frame_n | ~irdy_n;
    req = ~req_n & ~broken_q;
    park_vec = '0;
    park_vec[PARK] = PARK_EN;
    win_any = pick(req, int'(last_q));
    win_oth = pick(req & ~gnt_q, int'(last_q));
    cur_req = |(gnt_q & req);
    trip = cur_req && !busy && (bcnt_q == `PCIT_BROKEN_IDLE - 5'h01);
    bcnt_d = (cur_req && !busy) ? bcnt_q + 5'h01 : '0;
    // broken mark lasts while the agent keeps requesting
    broken_d = broken_q & ~req_n;
    gnt_d = gnt_q;
    if (gnt_q == '0) begin
      gnt_d = (req != '0) ? win_any : park_vec;
    end else if (trip) begin
      gnt_d = '0;
      broken_d = broken_d | gnt_q;
      bcnt_d = '0;
    end else if (busy) begin
      if (!frame_n && win_oth != '0) begin
        gnt_d = win_oth;
      end
    end else begin
      if (!cur_req && !(gnt_q == park_vec && req == '0)) begin
        gnt_d = '0;
      end
    end
    last_d = last_q;
    for (int i = 0; i < NAG; i++) begin
      if (gnt_d[i]) begin
        last_d = IW'(i);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gnt_q <= '0;
      broken_q <= '0;
      last_q <= '0;
      bcnt_q <= '0;
    end else begin
      gnt_q <= gnt_d;
      broken_q <= broken_d;
      last_q <= last_d;
      bcnt_q <= bcnt_d;
    end
  end

  assign gnt_n = ~gnt_q;
  assign broken_o = broken_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_one_grant: assert property ($onehot0(gnt_q))
    else $error("more than one grant");
  a_idle_gap: assert property ((!busy && gnt_q != '0) |=> (gnt_q == $past(gnt_q) || gnt_q == '0))
    else $error("grant moved on idle bus without gap");
  a_keep_cur: assert property ((busy && cur_req && (req & ~gnt_q) == '0) |=> gnt_q == $past(gnt_q))
    else $error("sole requester lost grant");
  a_broken_cut: assert property (trip |=> (gnt_q == '0 && broken_q != '0))
    else $error("broken master kept grant");
  a_withdraw_idle: assert property ((gnt_q != '0 && !busy && !cur_req
    && (gnt_q != park_vec || req != '0)) |=> gnt_q == '0)
    else $error("grant kept after request dropped");
  c_broken: cover property (trip);
  c_handoff: cover property (busy ##1 (gnt_q != $past(gnt_q) && gnt_q != '0));
endmodule // pcit_arb
`default_nettype wire

// File: pcit_mst_model.sv
// bus master model that drives the target and arbiter from the far side
`timescale 1ns/1ns
`default_nettype none
`include "pcit_params.svh"
module pcit_mst_model (
  input wire logic core_clk,
  input wire logic gnt_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic [31:0] ad_i,
  output logic [31:0] ad,
  output logic ad_oe_n,
  output logic [3:0] cbe_n,
  output logic cbe_oe_n,
  output logic frame_n,
  output logic irdy_n,
  output logic req_n
);
  logic [31:0] wdata [16];
  logic [31:0] rdata [16];
  int nxfer;
  logic stopped;

  initial begin
    ad = 32'h0;
    ad_oe_n = 1'b1;
    cbe_n = 4'hf;
    cbe_oe_n = 1'b1;
    frame_n = 1'b1;
    irdy_n = 1'b1;
    req_n = 1'b1;
    nxfer = 0;
    stopped = 1'b0;
  end

  // ****************************************
  // one transaction, iw idle clocks of irdy before each word
  // ****************************************
  task automatic run(input logic wr, input logic [31:0] addr, input int n, input int iw);
    int k;
    int w;
    logic xf;
    logic done;
    k = 0;
    w = 0;
    done = 1'b0;
    nxfer = 0;
    stopped = 1'b0;
    req_n = 1'b0;
    // grant and idle bus
    // never start without a grant; a missing grant hangs until the watchdog
    do begin
      @(posedge core_clk);
      k++;
    end while (!(gnt_n === 1'b0 && frame_n && irdy_n));
    @(negedge core_clk);
    frame_n = 1'b0;
    ad_oe_n = 1'b0;
    cbe_oe_n = 1'b0;
    ad = addr;
    cbe_n = wr ? `PCIT_CMD_MEMWR : `PCIT_CMD_MEMRD;
    req_n = 1'b1;
    @(negedge core_clk);
    cbe_n = 4'h0;
    ad_oe_n = !wr;
    k = 0;
    while (!done) begin
      irdy_n = (w < iw);
      if (wr) begin
        ad = wdata[nxfer % 16];
      end
      if (!irdy_n && (nxfer == n - 1 || stopped)) begin
        frame_n = 1'b1;
      end
      @(posedge core_clk);
      xf = !irdy_n && !trdy_n;
      if (xf && !wr) begin
        rdata[nxfer % 16] = ad_i;
      end
      if (xf) begin
        nxfer++;
        w = 0;
      end else if (irdy_n) begin
        w++;
      end
      if (!stop_n) begin
        stopped = 1'b1;
      end
      k++;
      done = (!irdy_n && frame_n && (xf || !stop_n)) || k > 300;
      @(negedge core_clk);
    end
    irdy_n = 1'b1;
    ad_oe_n = 1'b1;
    cbe_oe_n = 1'b1;
    // back off two clocks after stop
    if (stopped) begin
      repeat (2) @(negedge core_clk);
    end
  endtask
endmodule // pcit_mst_model
`default_nettype wire

// File: pcit_params.svh
// constants for the pci target and arbiter model
`ifndef PCIT_PARAMS_SVH
`define PCIT_PARAMS_SVH
`define PCIT_CMD_MEMRD 4'h6
`define PCIT_CMD_MEMWR 4'h7
`define PCIT_BROKEN_IDLE 5'h10
`define PCIT_BCNT_W 5
`define PCIT_CNT_W 16
`define PCIT_WAIT_W 4
`define PCIT_BURST_W 8
`define PCIT_DEF_DEPTH 16
`define PCIT_DEF_BURST 8
`define PCIT_DEF_BASE 32'h10000000
`define PCIT_DEF_NAG 2
`endif

// File: pcit_pkg.sv
// types shared by the pci target and arbiter model
`default_nettype none
package pcit_pkg;
  // bus lines as sampled by the target
  typedef struct packed {
    logic [31:0] ad;
    logic [3:0] cbe_n;
    logic frame_n;
    logic irdy_n;
  } pcit_bus_in_t;
  // target drive; an oe_n low means the line is driven
  typedef struct packed {
    logic [31:0] ad;
    logic ad_oe_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic ctl_oe_n;
  } pcit_tgt_out_t;
  typedef enum logic [2:0] {
    PCIT_S_IDLE = 3'b000,
    PCIT_S_TURN = 3'b001,
    PCIT_S_DATA = 3'b010,
    PCIT_S_STOP = 3'b011,
    PCIT_S_BACK = 3'b100
  } pcit_state_t;
endpackage
`default_nettype wire

// File: pcit_target.sv
// pci memory target with central arbiter, model of the bus outside a master
`timescale 1ns/1ns
`default_nettype none
`include "pcit_params.svh"
module pcit_target #(
  parameter int DEPTH = `PCIT_DEF_DEPTH,
  parameter int BURST = `PCIT_DEF_BURST,
  parameter logic [31:0] BASE = `PCIT_DEF_BASE,
  parameter int NAG = `PCIT_DEF_NAG
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire pcit_pkg::pcit_bus_in_t bus_i,
  output pcit_pkg::pcit_tgt_out_t bus_o,
  input wire logic [NAG-1:0] req_n,
  output logic [NAG-1:0] gnt_n,
  output logic [NAG-1:0] broken_o,
  input wire logic retry_i,
  input wire logic [`PCIT_WAIT_W-1:0] wait_i,
  output logic [`PCIT_CNT_W-1:0] xfer_cnt_o,
  output logic busy_o
);
  import pcit_pkg::*;
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || BURST < 1 || BURST > 255) begin : g_chk
    $error("pcit_target: depth must be a power of two, burst 1 to 255");
  end

  // ****************************************
  // state
  // ****************************************
  pcit_state_t state_q, state_d;
  logic [31:0] ad_q, ad_d, mem_wd;
  logic [31:0] mem_q [DEPTH];
  logic [AW-1:0] idx_q, idx_d, nxt_idx;
  logic [`PCIT_WAIT_W-1:0] wcnt_q, wcnt_d, wcfg_q, wcfg_d;
  logic [`PCIT_CNT_W-1:0] cnt_q, cnt_d;
  logic [`PCIT_BURST_W-1:0] burst_q, burst_d;
  logic devsel_q, devsel_d, trdy_q, trdy_d, stop_q, stop_d;
  logic ctl_oe_q, ctl_oe_d, ad_oe_q, ad_oe_d, rd_q, rd_d;
  logic idle_q, addr_phase, hit, is_rd, is_wr, xfer, mem_we;

  // byte lanes with cbe low take the new data
  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be_n);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (!be_n[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // decode
  // ****************************************
  always_comb begin
    // address phase is first frame low after idle
    addr_phase = !bus_i.frame_n && idle_q;
    hit = (bus_i.ad[31:AW+2] == BASE[31:AW+2]);
    is_rd = (bus_i.cbe_n == `PCIT_CMD_MEMRD);
    is_wr = (bus_i.cbe_n == `PCIT_CMD_MEMWR);
    // transfer needs both ready lines low
    xfer = !bus_i.irdy_n && !trdy_q && (state_q == PCIT_S_DATA);
    nxt_idx = idx_q + 1'b1;
  end

  // ****************************************
  // target sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    devsel_d = devsel_q;
    trdy_d = trdy_q;
    stop_d = stop_q;
    ctl_oe_d = ctl_oe_q;
    ad_oe_d = ad_oe_q;
    ad_d = ad_q;
    idx_d = idx_q;
    wcnt_d = wcnt_q;
    wcfg_d = wcfg_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    burst_d = burst_q;
    mem_we = 1'b0;
    mem_wd = bmerge(mem_q[idx_q], bus_i.ad, bus_i.cbe_n);
    unique case (state_q)
      PCIT_S_IDLE: begin
        if (addr_phase && hit && (is_rd || is_wr)) begin
          idx_d = bus_i.ad[AW+1:2];
          rd_d = is_rd;
          wcfg_d = wait_i;
          wcnt_d = wait_i;
          burst_d = '0;
          devsel_d = 1'b0;
          ctl_oe_d = 1'b0;
          if (retry_i) begin
            // retry: claim and stop, no data moves
            stop_d = 1'b0;
            state_d = PCIT_S_STOP;
          end else if (is_rd) begin
            state_d = PCIT_S_TURN;
          end else begin
            // write data phase starts at once
            trdy_d = (wait_i != '0);
            state_d = PCIT_S_DATA;
          end
        end
      end
      PCIT_S_TURN: begin
        // drive ad after turnaround with devsel low
        ad_oe_d = 1'b0;
        ad_d = mem_q[idx_q];
        // trdy only once devsel is low
        trdy_d = (wcnt_q != '0);
        state_d = PCIT_S_DATA;
      end
      PCIT_S_DATA: begin
        if (xfer) begin
          cnt_d = cnt_q + 16'h0001;
          burst_d = burst_q + 8'h01;
          mem_we = !rd_q;
          // frame high at the transfer marks the last phase
          if (bus_i.frame_n) begin
            devsel_d = 1'b1;
            trdy_d = 1'b1;
            ad_oe_d = 1'b1;
            state_d = PCIT_S_BACK;
          end else if (burst_q == 8'(BURST - 1)) begin
            // disconnect keeps the bus from being held for long bursts
            trdy_d = 1'b1;
            stop_d = 1'b0;
            state_d = PCIT_S_STOP;
          end else begin
            idx_d = nxt_idx;
            ad_d = mem_q[nxt_idx];
            wcnt_d = wcfg_q;
            trdy_d = (wcfg_q != '0);
          end
        end else if (trdy_q) begin
          wcnt_d = wcnt_q - 4'h1;
          trdy_d = (wcnt_q != 4'h1);
        end
      end
      PCIT_S_STOP: begin
        // wait for the master to close the frame
        if (bus_i.frame_n) begin
          devsel_d = 1'b1;
          stop_d = 1'b1;
          ad_oe_d = 1'b1;
          state_d = PCIT_S_BACK;
        end
      end
      PCIT_S_BACK: begin
        // lines were driven high one clock; now release them
        ctl_oe_d = 1'b1;
        state_d = PCIT_S_IDLE;
      end
      default: begin
        state_d = PCIT_S_IDLE;
        devsel_d = 1'b1;
        trdy_d = 1'b1;
        stop_d = 1'b1;
        ctl_oe_d = 1'b1;
        ad_oe_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= PCIT_S_IDLE;
      devsel_q <= 1'b1;
      trdy_q <= 1'b1;
      stop_q <= 1'b1;
      ctl_oe_q <= 1'b1;
      ad_oe_q <= 1'b1;
      ad_q <= '0;
      idx_q <= '0;
      wcnt_q <= '0;
      wcfg_q <= '0;
      rd_q <= 1'b0;
      cnt_q <= '0;
      burst_q <= '0;
      idle_q <= 1'b0;
    end else begin
      state_q <= state_d;
      devsel_q <= devsel_d;
      trdy_q <= trdy_d;
      stop_q <= stop_d;
      ctl_oe_q <= ctl_oe_d;
      ad_oe_q <= ad_oe_d;
      ad_q <= ad_d;
      idx_q <= idx_d;
      wcnt_q <= wcnt_d;
      wcfg_q <= wcfg_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      burst_q <= burst_d;
      // idle when frame and irdy both high
      idle_q <= bus_i.frame_n && bus_i.irdy_n;
    end
  end

  // storage has no reset; contents are undefined until written
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem_q[idx_q] <= mem_wd;
    end
  end

  // ****************************************
  // arbiter and outputs
  // ****************************************
  pcit_arb #(.NAG(NAG), .PARK(0), .PARK_EN(1'b1)) u_arb (
    .core_clk(core_clk),
    .rstn(rstn),
    .frame_n(bus_i.frame_n),
    .irdy_n(bus_i.irdy_n),
    .req_n(req_n),
    .gnt_n(gnt_n),
    .broken_o(broken_o)
  );

  always_comb begin
    bus_o.ad = ad_q;
    bus_o.ad_oe_n = ad_oe_q;
    bus_o.trdy_n = trdy_q;
    bus_o.devsel_n = devsel_q;
    bus_o.stop_n = stop_q;
    bus_o.ctl_oe_n = ctl_oe_q;
  end
  assign xfer_cnt_o = cnt_q;
  assign busy_o = (state_q != PCIT_S_IDLE);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_trdy_devsel: assert property (!bus_o.trdy_n |-> !bus_o.devsel_n)
    else $error("trdy low without devsel");
  a_read_turn: assert property ((state_q == PCIT_S_IDLE && addr_phase && hit && is_rd && !retry_i)
    |=> (bus_o.ad_oe_n && !bus_o.devsel_n && bus_o.trdy_n) ##1 !bus_o.ad_oe_n)
    else $error("read turnaround broken");
  a_ad_held: assert property ((!bus_o.ad_oe_n && state_q == PCIT_S_DATA
    && !(xfer && bus_i.frame_n)) |=> !bus_o.ad_oe_n)
    else $error("ad released mid transaction");
  a_xfer_cnt: assert property (xfer |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("transfer not counted");
  a_wait_none: assert property (!xfer |=> $stable(cnt_q))
    else $error("wait cycle moved data");
  a_write_noturn: assert property ((state_q == PCIT_S_IDLE && addr_phase && hit && is_wr
    && !retry_i && wait_i == '0) |=> !bus_o.trdy_n && !bus_o.devsel_n)
    else $error("write inserted turnaround");
  a_end_idle: assert property ((xfer && bus_i.frame_n) |=> state_q == PCIT_S_BACK
    ##1 (state_q == PCIT_S_IDLE && bus_o.ctl_oe_n))
    else $error("last phase did not end transaction");
  a_stay_claimed: assert property ((state_q inside {PCIT_S_TURN, PCIT_S_DATA, PCIT_S_STOP}
    && !bus_i.frame_n) |=> state_q != PCIT_S_IDLE)
    else $error("transaction dropped while frame low");
  c_read: cover property (xfer && rd_q && bus_i.frame_n);
  c_write: cover property (xfer && !rd_q ##1 xfer);
  c_retry: cover property (state_q == PCIT_S_STOP && burst_q == '0);
endmodule // pcit_target
`default_nettype wire

// File: testbench.sv
// self-checking bench for the target and arbiter
`timescale 1ns/1ns
`default_nettype none
`include "pcit_params.svh"
module testbench;
  import pcit_pkg::*;
  logic core_clk;
  logic rstn;
  pcit_bus_in_t bus_i;
  pcit_tgt_out_t bus_o;
  logic [1:0] req_n;
  logic [1:0] gnt_n;
  logic [1:0] broken_o;
  logic retry_i;
  logic [3:0] wait_i;
  logic [15:0] xfer_cnt_o;
  logic busy_o;
  logic [31:0] m_ad;
  logic m_ad_oe_n;
  logic [3:0] m_cbe_n;
  logic m_cbe_oe_n;
  logic m_frame_n;
  logic m_irdy_n;
  logic m_req_n;
  logic req1_n;
  logic trdy_w;
  logic stop_w;
  logic [31:0] ad_last;
  logic [3:0] cbe_last;
  logic [15:0] c0;
  int n_errors;
  int tests_run;
  int dsel_n;

  assign req_n = {req1_n, m_req_n};

  // ****************************************
  // wire resolution; released lines do not keep their value
  // ****************************************
  always_comb begin
    bus_i.ad = !m_ad_oe_n ? m_ad : (!bus_o.ad_oe_n ? bus_o.ad : ~ad_last);
    bus_i.cbe_n = !m_cbe_oe_n ? m_cbe_n : ~cbe_last;
    bus_i.frame_n = m_frame_n;
    bus_i.irdy_n = m_irdy_n;
    trdy_w = bus_o.ctl_oe_n | bus_o.trdy_n;
    stop_w = bus_o.ctl_oe_n | bus_o.stop_n;
  end

  always @(posedge core_clk) begin
    ad_last <= bus_i.ad;
    cbe_last <= bus_i.cbe_n;
  end

  // edges at which the target shows a claim, as a master samples them
  always @(posedge core_clk) begin
    if (!bus_o.devsel_n && !bus_o.ctl_oe_n) begin
      dsel_n <= dsel_n + 1;
    end
  end

  pcit_target dut (
    .core_clk(core_clk), .rstn(rstn), .bus_i(bus_i), .bus_o(bus_o), .req_n(req_n),
    .gnt_n(gnt_n), .broken_o(broken_o), .retry_i(retry_i), .wait_i(wait_i),
    .xfer_cnt_o(xfer_cnt_o), .busy_o(busy_o)
  );

  pcit_mst_model mst (
    .core_clk(core_clk), .gnt_n(gnt_n[0]), .trdy_n(trdy_w), .stop_n(stop_w),
    .ad_i(bus_i.ad), .ad(m_ad), .ad_oe_n(m_ad_oe_n), .cbe_n(m_cbe_n),
    .cbe_oe_n(m_cbe_oe_n), .frame_n(m_frame_n), .irdy_n(m_irdy_n), .req_n(m_req_n)
  );

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check("gnt in reset", 32'(gnt_n), 32'h3);
    check("ctl oe in reset", 32'(bus_o.ctl_oe_n), 32'h1);
    check("ad oe in reset", 32'(bus_o.ad_oe_n), 32'h1);
    check("count in reset", 32'(xfer_cnt_o), 32'h0);
    check("busy in reset", 32'(busy_o), 32'h0);
    check("broken in reset", 32'(broken_o), 32'h0);
  endtask

  // burst write, then read back with waits on both sides
  task automatic t_burst();
    int d0;
    for (int i = 0; i < 3; i++) begin
      mst.wdata[i] = 32'h3c5a0000 + 32'(i * 17);
    end
    c0 = xfer_cnt_o;
    d0 = dsel_n;
    mst.run(1'b1, `PCIT_DEF_BASE, 3, 0);
    check("write words", 32'(mst.nxfer), 32'h3);
    check("write claim clocks", 32'(dsel_n - d0), 32'h3);
    wait_i = 4'h2;
    d0 = dsel_n;
    mst.run(1'b0, `PCIT_DEF_BASE, 3, 1);
    check("read words", 32'(mst.nxfer), 32'h3);
    // one turnaround clock, then three words of two target waits each
    check("read claim clocks", 32'(dsel_n - d0), 32'ha);
    for (int i = 0; i < 3; i++) begin
      check("read data", mst.rdata[i], 32'h3c5a0000 + 32'(i * 17));
    end
    check("count burst", 32'(xfer_cnt_o), 32'(c0 + 16'h6));
    wait_i = 4'h0;
  endtask

  // target retries, master backs off and comes again
  task automatic t_retry();
    int d0;
    c0 = xfer_cnt_o;
    d0 = dsel_n;
    retry_i = 1'b1;
    mst.run(1'b1, `PCIT_DEF_BASE, 2, 0);
    check("retry stop", 32'(mst.stopped), 32'h1);
    check("retry words", 32'(mst.nxfer), 32'h0);
    check("retry claim clocks", 32'(dsel_n - d0), 32'h2);
    retry_i = 1'b0;
    mst.run(1'b1, `PCIT_DEF_BASE, 2, 0);
    check("repeat words", 32'(mst.nxfer), 32'h2);
    check("count retry", 32'(xfer_cnt_o), 32'(c0 + 16'h2));
  endtask

  // burst longer than the target allows is cut by stop
  task automatic t_disc();
    c0 = xfer_cnt_o;
    mst.run(1'b1, `PCIT_DEF_BASE, 10, 0);
    check("disc words", 32'(mst.nxfer), 32'h8);
    check("disc stop", 32'(mst.stopped), 32'h1);
    check("count disc", 32'(xfer_cnt_o), 32'(c0 + 16'h8));
  endtask

  // second agent: grant gap from idle, then never starts
  task automatic t_arb();
    int k;
    req1_n = 1'b0;
    @(negedge core_clk);
    check("gnt gap", 32'(gnt_n), 32'h3);
    @(negedge core_clk);
    check("gnt moved", 32'(gnt_n), 32'h1);
    k = 0;
    while (broken_o[1] !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    check("broken window", 32'(k >= 15 && k <= 18), 32'h1);
    check("broken gnt off", 32'(gnt_n[1]), 32'h1);
    req1_n = 1'b1;
    repeat (3) @(negedge core_clk);
    check("broken clears", 32'(broken_o), 32'h0);
    check("idle busy", 32'(busy_o), 32'h0);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    conclude();
  end

  initial begin
    rstn = 1'b0;
    retry_i = 1'b0;
    wait_i = 4'h0;
    req1_n = 1'b1;
    ad_last = 32'h0;
    cbe_last = 4'h0;
    n_errors = 0;
    tests_run = 0;
    dsel_n = 0;
    repeat (12) @(negedge core_clk);
    t_reset();
    rstn = 1'b1;
    repeat (2) @(negedge core_clk);
    t_burst();
    t_retry();
    t_disc();
    repeat (3) @(negedge core_clk);
    t_arb();
    conclude();
  end
endmodule // testbench
`default_nettype wire
